//--- logic/esf_event_flags.sv
// Event status bits 5 to 2 with their source registers and interrupt routing
//
// How it works
// (RULE_01) Bit 5 reads one while the fifo is on and overflow, gate-error or (outside triggered mode) watermark is active, else zero.
// (RULE_02) Watermark and overflow are shown in the fifo state register, gate-error in the system state register.
// (RULE_03) Bit 5 stays zero while the fifo mode field is 00b.
// (RULE_04) In triggered mode the watermark flag still asserts but neither sets bit 5 nor drives a pin.
// (RULE_05) A full fifo sets bit 5 and, when enabled, drives interrupt pin one or two.
// (RULE_06) A host wanting the trigger moment should watch the change detector or attitude interrupts.
// (RULE_07) Bit 4 always equals the outside-threshold active flag of change detector source one.
// (RULE_08) With its latch enabled bit 4 clears only on a read of source one, else when the condition drops.
// (RULE_09) Bit 3 always equals the within-threshold active flag of change detector source two.
// (RULE_10) With its latch enabled bit 3 clears only on a read of source two, else when the condition drops.
// (RULE_11) Bit 2 is set when an attitude change is detected and the fresh attitude bit is asserted.
// (RULE_12) Reading the attitude state register clears the attitude change bit.
// (RULE_13) Reading the event status register clears none of bits 5 to 2.
`timescale 1ns/10ps
`default_nettype none

module esf_event_flags (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [esf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [esf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [esf_pkg::DATA_W-1:0] reg_rdata,
  // Fifo engine
  input wire logic fifo_watermark,
  input wire logic fifo_full,
  input wire logic fifo_gate_error,
  // Change detector engine
  input wire logic outside_threshold_cond,
  input wire logic within_threshold_cond,
  // Attitude engine
  input wire logic attitude_change,
  input wire logic [esf_pkg::ATT_CODE_W-1:0] attitude_code,
  // Interrupts
  output logic irq,
  output logic irq_pin_one,
  output logic irq_pin_two
);
  import esf_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  logic wr_fifo_cfg;
  logic wr_cd_cfg;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_pin_enable;
  logic wr_pin_route;
  logic rd_system;
  logic rd_cd_src1;
  logic rd_cd_src2;
  logic rd_att;

  assign wr_fifo_cfg = reg_wr && (reg_addr == OFS_FIFO_CFG1);
  assign wr_cd_cfg = reg_wr && (reg_addr == OFS_CD_CFG1);
  assign wr_irq_status = reg_wr && (reg_addr == OFS_IRQ_STATUS);
  assign wr_irq_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);
  assign wr_pin_enable = reg_wr && (reg_addr == OFS_PIN_ENABLE);
  assign wr_pin_route = reg_wr && (reg_addr == OFS_PIN_ROUTE);
  assign rd_system = reg_rd && (reg_addr == OFS_SYSTEM_STATE);
  assign rd_cd_src1 = reg_rd && (reg_addr == OFS_CD_SRC1);
  assign rd_cd_src2 = reg_rd && (reg_addr == OFS_CD_SRC2);
  assign rd_att = reg_rd && (reg_addr == OFS_ATT_STATE);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [DATA_W-1:0] fifo_config_register_one;
  logic [DATA_W-1:0] change_detector_config_one;
  logic [DATA_W-1:0] irq_mask;
  logic [DATA_W-1:0] pin_enable;
  logic [DATA_W-1:0] pin_route;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_config_register_one <= RST_REG;
      change_detector_config_one <= RST_REG;
      irq_mask <= RST_REG;
      pin_enable <= RST_REG;
      pin_route <= RST_REG;
    end else begin
      if (wr_fifo_cfg) begin
        fifo_config_register_one <= reg_wdata;
      end
      if (wr_cd_cfg) begin
        change_detector_config_one <= reg_wdata;
      end
      if (wr_irq_mask) begin
        irq_mask <= reg_wdata;
      end
      if (wr_pin_enable) begin
        pin_enable <= reg_wdata;
      end
      if (wr_pin_route) begin
        pin_route <= reg_wdata;
      end
    end
  end

  logic [1:0] fifo_mode;
  logic fifo_on;
  logic fifo_trig;
  logic outside_threshold_latch_enable;
  logic within_threshold_latch_enable;

  assign fifo_mode = fifo_config_register_one[FIFO_MODE_LSB +: 2];
  assign fifo_on = (fifo_mode != FIFO_MODE_OFF);
  assign fifo_trig = (fifo_mode == FIFO_MODE_TRIG);
  assign outside_threshold_latch_enable = change_detector_config_one[BIT_OT_LATCH];
  assign within_threshold_latch_enable = change_detector_config_one[BIT_WT_LATCH];

  // ****************************************
  // Fifo flags
  // ****************************************
  logic fifo_watermark_flag;
  logic fifo_overflow_flag;
  logic fifo_gate_error_flag;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_watermark_flag <= 1'b0;
      fifo_overflow_flag <= 1'b0;
      fifo_gate_error_flag <= 1'b0;
    end else begin
      fifo_watermark_flag <= fifo_on && fifo_watermark; // RULE_04
      fifo_overflow_flag <= fifo_on && fifo_full; // RULE_05
      fifo_gate_error_flag <= fifo_gate_error || (fifo_gate_error_flag && !rd_system); // RULE_02
    end
  end

  logic buffer_event_bit;

  assign buffer_event_bit = fifo_on && ((fifo_watermark_flag && !fifo_trig) // RULE_03 RULE_04
    || fifo_overflow_flag || fifo_gate_error_flag); // RULE_01 RULE_05

  // ****************************************
  // Change detector flags
  // ****************************************
  logic outside_threshold_active;
  logic within_threshold_active;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      outside_threshold_active <= 1'b0;
    end else begin
      outside_threshold_active <= outside_threshold_cond
        || (outside_threshold_latch_enable && outside_threshold_active && !rd_cd_src1); // RULE_08
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      within_threshold_active <= 1'b0;
    end else begin
      within_threshold_active <= within_threshold_cond
        || (within_threshold_latch_enable && within_threshold_active && !rd_cd_src2); // RULE_10
    end
  end

  // ****************************************
  // Attitude flags
  // ****************************************
  logic fresh_attitude_bit;
  logic [ATT_CODE_W-1:0] att_code;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fresh_attitude_bit <= 1'b0;
      att_code <= RST_ATT_CODE;
    end else begin
      fresh_attitude_bit <= attitude_change || (fresh_attitude_bit && !rd_att); // RULE_11 RULE_12
      if (attitude_change) begin
        att_code <= attitude_code;
      end
    end
  end

  // ****************************************
  // Event status vector
  // ****************************************
  logic [DATA_W-1:0] event_vec;

  always_comb begin
    event_vec = RST_REG;
    event_vec[BIT_BUF_EVT] = buffer_event_bit; // RULE_01
    event_vec[BIT_OT_EVT] = outside_threshold_active; // RULE_07
    event_vec[BIT_WT_EVT] = within_threshold_active; // RULE_09
    event_vec[BIT_ATT_EVT] = fresh_attitude_bit; // RULE_11
  end

  // ****************************************
  // Sticky interrupt status
  // ****************************************
  logic [DATA_W-1:0] irq_status;
  wire logic [DATA_W-1:0] next_irq_status;

  // Set wins over write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_sticky
      if (gi >= EVT_LO && gi <= EVT_HI) begin : g_evt
        assign next_irq_status[gi] = event_vec[gi] || (irq_status[gi] && !(wr_irq_status && reg_wdata[gi]));
      end else begin : g_none
        assign next_irq_status[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= RST_REG;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
      irq_pin_one <= 1'b0;
      irq_pin_two <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
      irq_pin_one <= |(event_vec & pin_enable & ~pin_route); // RULE_05
      irq_pin_two <= |(event_vec & pin_enable & pin_route); // RULE_05
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = RST_REG;
    case (reg_addr)
      OFS_EVENT_STATUS: begin
        next_rdata = event_vec; // RULE_13
      end
      OFS_FIFO_STATE: begin
        next_rdata[BIT_FIFO_WMRK] = fifo_watermark_flag; // RULE_02
        next_rdata[BIT_FIFO_OVF] = fifo_overflow_flag;
      end
      OFS_SYSTEM_STATE: begin
        next_rdata[BIT_GATE_ERR] = fifo_gate_error_flag; // RULE_02
      end
      OFS_FIFO_CFG1: begin
        next_rdata = fifo_config_register_one;
      end
      OFS_CD_CFG1: begin
        next_rdata = change_detector_config_one;
      end
      OFS_CD_SRC1: begin
        next_rdata[BIT_OT_ACTIVE] = outside_threshold_active;
      end
      OFS_CD_SRC2: begin
        next_rdata[BIT_WT_ACTIVE] = within_threshold_active;
      end
      OFS_ATT_STATE: begin
        next_rdata[BIT_FRESH_ATT] = fresh_attitude_bit;
        next_rdata[ATT_CODE_W-1:0] = att_code;
      end
      OFS_IRQ_STATUS: begin
        next_rdata = irq_status;
      end
      OFS_IRQ_MASK: begin
        next_rdata = irq_mask;
      end
      OFS_PIN_ENABLE: begin
        next_rdata = pin_enable;
      end
      OFS_PIN_ROUTE: begin
        next_rdata = pin_route;
      end
      default: begin
        next_rdata = RST_REG;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RST_REG;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= RST_REG;
    end
  end

endmodule : esf_event_flags

`default_nettype wire

//--- common/esf_pkg.sv
// Constants for the interrupt event status flag logic (bits 5 to 2)
package esf_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h00;
  localparam logic [7:0] OFS_FIFO_STATE = 8'h01;
  localparam logic [7:0] OFS_SYSTEM_STATE = 8'h02;
  localparam logic [7:0] OFS_FIFO_CFG1 = 8'h03;
  localparam logic [7:0] OFS_CD_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CD_SRC1 = 8'h05;
  localparam logic [7:0] OFS_CD_SRC2 = 8'h06;
  localparam logic [7:0] OFS_ATT_STATE = 8'h07;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h09;
  localparam logic [7:0] OFS_PIN_ENABLE = 8'h0A;
  localparam logic [7:0] OFS_PIN_ROUTE = 8'h0B;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_BUF_EVT = 5;
  localparam int BIT_OT_EVT = 4;
  localparam int BIT_WT_EVT = 3;
  localparam int BIT_ATT_EVT = 2;
  localparam int EVT_LO = 2;
  localparam int EVT_HI = 5;
  localparam int BIT_FIFO_WMRK = 7;
  localparam int BIT_FIFO_OVF = 6;
  localparam int BIT_GATE_ERR = 7;
  localparam int FIFO_MODE_LSB = 6;
  localparam int BIT_OT_LATCH = 7;
  localparam int BIT_WT_LATCH = 6;
  localparam int BIT_OT_ACTIVE = 7;
  localparam int BIT_WT_ACTIVE = 7;
  localparam int BIT_FRESH_ATT = 7;
  localparam int ATT_CODE_W = 3;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] FIFO_MODE_OFF = 2'h0;
  localparam logic [1:0] FIFO_MODE_TRIG = 2'h3;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [ATT_CODE_W-1:0] RST_ATT_CODE = 3'h0;

endpackage : esf_pkg

//--- tb/esf_event_flags_checker.sv
// Concurrent checks on event status bits 5 to 2
`timescale 1ns/10ps
`default_nettype none
module esf_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [esf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [esf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [esf_pkg::DATA_W-1:0] reg_rdata,
  // Event sources
  input wire logic fifo_full,
  input wire logic outside_threshold_cond,
  input wire logic within_threshold_cond,
  input wire logic attitude_change
);
  import esf_pkg::*;
  logic [1:0] mode;
  logic [1:0] latch;
  // Shadow of fifo mode and latch enables
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= 2'h0;
      latch <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_FIFO_CFG1) begin
        mode <= reg_wdata[FIFO_MODE_LSB +: 2];
      end
      if (reg_addr == OFS_CD_CFG1) begin
        latch <= {reg_wdata[BIT_OT_LATCH], reg_wdata[BIT_WT_LATCH]};
      end
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd_stat;
    reg_rd && reg_addr == OFS_EVENT_STATUS;
  endsequence
  sequence s_rd_att;
    reg_rd && reg_addr == OFS_ATT_STATE;
  endsequence
  a_buf_off_zero: assert property ((mode == FIFO_MODE_OFF)[*2] ##0 s_rd_stat |=> !reg_rdata[BIT_BUF_EVT])
    else $error("buffer bit set with fifo off");
  a_buf_full_sets: assert property ((mode != FIFO_MODE_OFF && fifo_full)[*3] ##0 s_rd_stat |=> reg_rdata[BIT_BUF_EVT])
    else $error("buffer bit missing on full");
  a_ovf_detail_shown: assert property ((mode != FIFO_MODE_OFF && fifo_full)[*3] ##0 reg_rd
    && reg_addr == OFS_FIFO_STATE |=> reg_rdata[BIT_FIFO_OVF]) else $error("overflow detail missing");
  a_ot_follows: assert property (outside_threshold_cond[*3] ##0 s_rd_stat |=> reg_rdata[BIT_OT_EVT])
    else $error("outside bit missing");
  a_ot_self_clear: assert property ((!latch[1] && !outside_threshold_cond)[*3] ##0 s_rd_stat |=> !reg_rdata[BIT_OT_EVT])
    else $error("outside bit stuck");
  a_wt_follows: assert property (within_threshold_cond[*3] ##0 s_rd_stat |=> reg_rdata[BIT_WT_EVT])
    else $error("within bit missing");
  a_wt_self_clear: assert property ((!latch[0] && !within_threshold_cond)[*3] ##0 s_rd_stat |=> !reg_rdata[BIT_WT_EVT])
    else $error("within bit stuck");
  a_att_sets: assert property (attitude_change ##1 (!reg_rd && !attitude_change) ##1 s_rd_stat |=> reg_rdata[BIT_ATT_EVT])
    else $error("attitude bit missing");
  a_att_read_clears: assert property ((s_rd_att and !attitude_change) ##1 (!reg_rd && !attitude_change)
    ##1 s_rd_stat |=> !reg_rdata[BIT_ATT_EVT]) else $error("attitude bit not cleared");
  a_status_keeps: assert property (s_rd_stat ##1 (s_rd_stat and reg_rdata[BIT_ATT_EVT]) |=> reg_rdata[BIT_ATT_EVT])
    else $error("status read cleared a bit");
endmodule : esf_checker
bind esf_event_flags esf_checker u_chk (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fifo_full, .outside_threshold_cond, .within_threshold_cond, .attitude_change);
`default_nettype wire

//--- tb/esf_host.sv
// Host processor model on the register port
`timescale 1ns/10ps
`default_nettype none
module esf_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [esf_pkg::ADDR_W-1:0] reg_addr,
  output logic [esf_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [esf_pkg::DATA_W-1:0] reg_rdata
);
  import esf_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // n back-to-back reads of one address, returning the first and last data
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d1, output logic [7:0] d2);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (i == n - 1) begin
        reg_rd <= 1'b0;
        reg_addr <= ~a;
      end
      @(negedge ref_clk);
      if (i == 0) d1 = reg_rdata;
      d2 = reg_rdata;
    end
  endtask : rd
endmodule : esf_host
`default_nettype wire

//--- tb/esf_event_flags_tb.sv
// Self-checking bench for event status bits 5 to 2
`timescale 1ns/10ps
`default_nettype none
module esf_event_flags_tb;
  import esf_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d1, d2;
  logic reg_wr, reg_rd, irq, irq_pin_one, irq_pin_two;
  logic fifo_watermark = 1'b0, fifo_full = 1'b0, fifo_gate_error = 1'b0, attitude_change = 1'b0;
  logic outside_threshold_cond = 1'b0, within_threshold_cond = 1'b0;
  logic [2:0] attitude_code = 3'h0;
  int fail_count = 0;
  int total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  esf_event_flags u_dut (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fifo_watermark,
    .fifo_full, .fifo_gate_error, .outside_threshold_cond, .within_threshold_cond, .attitude_change, .attitude_code,
    .irq, .irq_pin_one, .irq_pin_two);
  esf_host u_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  function automatic logic exp_buf(logic [1:0] m, logic wm, logic ovf, logic ge);
    return (m != FIFO_MODE_OFF) && ((wm && m != FIFO_MODE_TRIG) || ovf || ge);
  endfunction : exp_buf
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    u_host.rd(a, 1, d1, d2);
    chk(d1 & m, e);
  endtask : rchk
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [1:0] m;
    logic [2:0] code;
    logic r;
    logic e;
    void'($urandom(61));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    u_host.wr(OFS_EVENT_STATUS, 8'hFF);
    rchk(OFS_EVENT_STATUS, 8'hFF, 8'h00);
    rchk(8'hFF, 8'hFF, 8'h00);
    r = 1'($urandom_range(1));
    u_host.wr(OFS_PIN_ENABLE, 8'h20);
    u_host.wr(OFS_PIN_ROUTE, {2'h0, r, 5'h00});
    for (int i = 0; i < 8; i++) begin
      m = i[1:0];
      u_host.wr(OFS_FIFO_CFG1, {m, 6'h00});
      fifo_watermark <= 1'b1;
      fifo_full <= i[2];
      settle();
      e = exp_buf(m, 1'b1, i[2], 1'b0);
      rchk(OFS_EVENT_STATUS, 8'h20, {2'h0, e, 5'h00});
      rchk(OFS_FIFO_STATE, 8'hC0, (m == FIFO_MODE_OFF) ? 8'h00 : {1'b1, i[2], 6'h00});
      chk({6'h0, irq_pin_two, irq_pin_one}, {6'h0, r & e, ~r & e});
    end
    @(posedge ref_clk);
    fifo_watermark <= 1'b0;
    fifo_full <= 1'b0;
    u_host.wr(OFS_IRQ_MASK, 8'h18);
    for (int k = 0; k < 4; k++) begin
      u_host.wr(OFS_CD_CFG1, {k[1] & ~k[0], k[1] & k[0], 6'h00});
      outside_threshold_cond <= ~k[0];
      within_threshold_cond <= k[0];
      settle();
      rchk(OFS_EVENT_STATUS, 8'h18, 8'h10 >> k[0]);
      chk({7'h0, irq}, 8'h01);
      @(posedge ref_clk);
      outside_threshold_cond <= 1'b0;
      within_threshold_cond <= 1'b0;
      settle();
      rchk(OFS_EVENT_STATUS, 8'h18, k[1] ? 8'h10 >> k[0] : 8'h00);
      rchk(OFS_CD_SRC1 + 8'(k[0]), 8'h80, {k[1], 7'h00});
      rchk(OFS_EVENT_STATUS, 8'h18, 8'h00);
      u_host.wr(OFS_IRQ_MASK, 8'h00);
      settle();
      chk({7'h0, irq}, 8'h00);
      u_host.wr(OFS_IRQ_MASK, 8'h18);
      u_host.wr(OFS_IRQ_STATUS, 8'h18);
      settle();
      chk({7'h0, irq}, 8'h00);
    end
    u_host.wr(OFS_FIFO_CFG1, 8'h40);
    fifo_gate_error <= 1'b1;
    @(posedge ref_clk);
    fifo_gate_error <= 1'b0;
    settle();
    rchk(OFS_EVENT_STATUS, 8'h20, 8'h20);
    rchk(OFS_SYSTEM_STATE, 8'h80, 8'h80);
    rchk(OFS_EVENT_STATUS, 8'h20, 8'h00);
    repeat (3) begin
      code = 3'($urandom_range(7));
      @(posedge ref_clk);
      attitude_change <= 1'b1;
      attitude_code <= code;
      @(posedge ref_clk);
      attitude_change <= 1'b0;
      attitude_code <= ~code;
      u_host.rd(OFS_EVENT_STATUS, 2, d1, d2);
      chk(d1 & 8'h04, 8'h04);
      chk(d2 & 8'h04, 8'h04);
      rchk(OFS_ATT_STATE, 8'h87, {5'h10, code});
      rchk(OFS_EVENT_STATUS, 8'h04, 8'h00);
    end
    // Mid-run reset clears sticky status and config
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk(OFS_IRQ_STATUS, 8'hFF, 8'h00);
    rchk(OFS_FIFO_CFG1, 8'hFF, 8'h00);
    rchk(OFS_EVENT_STATUS, 8'hFF, 8'h00);
    give_verdict();
  end
endmodule : esf_event_flags_tb
`default_nettype wire
